// *** core/cabd_decoder.sv ***
// Address, chip-select and data-bus steering decoder for an 8-bit CPU board
//
// Functional notes
// - Page zero qualified only when address bits 15..8 are all low.
// - Page zero with bit 7 low selects on-chip RAM, internal bus off.
// - Page zero with bit 7 high asserts peripheral group select, low active.
// - In the group bit 6 high picks GPIB, low picks adapter.
// - GPIB select only while clock and buffered valid address both high.
// - Adapter clock comes straight from the buffered system clock.
// - Primary decoder splits space by bits 15..13, enabled by valid address.
// - Blocks 2..6 unused for external bank; block 7 selects system ROM.
// - Secondary decoder enabled for 2000-3FFF, bits 12..11 pick output.
// - System RAM selected for 2000-27FF.
// - Signature trigger driven from fourth secondary output.
// - Write to 3000 gives code 00, latch loads in clock low half.
// - Read of 3000 gives code 01, enables switches, both buses off.
// - Select latch is write only; software keeps its own copy.
// - Write latch transparent with clock high, holds when clock low.
// - Internal bus driven by write latch only when its enable is active.
// - Read buffer on only with clock high, data enable low, and read.
// - Internal data enable low for 0000-3FFF and E000-FFFF, except on-chip RAM and switch read.
// - External bus for 4000-DFFF; direction follows read/write line.
// - Internal and external buses never enabled together.
// - Switch register drives data lines only while its enable is low.
`default_nettype none
module cabd_decoder
  import cabd_pkg::*;
(
  input  wire logic              mclk_i,      // 100 MHz system clock
  input  wire logic              rstn_i,      // Async reset, active low
  input  wire cabd_pkg::cabd_cpu_t cpu_i,     // Address and strobes
  input  wire logic [7:0]        cpu_data_i,  // Processor write data
  input  wire logic [7:0]        switch_i,    // Address switch settings
  output logic [7:0]             int_data_o,  // Internal data bus out
  output logic                   int_data_oe_o, // Internal bus drive enable
  output logic [7:0]             cpu_data_o,  // Data to processor
  output logic                   cpu_data_oe_o, // Processor bus drive enable
  output logic [7:0]             sel_latch_o, // Circuit select latch
  output cabd_pkg::cabd_sel_t    sel_o,       // Chip selects
  output cabd_pkg::cabd_bus_t    bus_o        // Bus steering
);
  import cabd_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  logic [15:0] a;
  logic        clk_b;
  logic        vma;
  logic        rd;
  logic        page0;
  logic [7:0]  blk_n;
  logic        sec_en;
  logic [3:0]  sub_n;
  logic [1:0]  reg_code;
  logic        int_region;
  logic        ext_region;
  logic        sw_read;
  logic        cpu_ram;
  cabd_sel_t   next_sel;
  cabd_bus_t   next_bus;

  assign a     = cpu_i.internal_addr_bits;
  assign clk_b = cpu_i.buffered_sys_clock;
  assign vma   = cpu_i.buffered_valid_addr;
  assign rd    = cpu_i.internal_read_write;

  assign page0   = (a[CABD_PAGE_HI:CABD_PAGE_LO] == 8'h00);
  assign cpu_ram = page0 && !a[CABD_PAGE_GRP_BIT];

  // primary one-of-eight, enabled by valid address only
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_blk
      assign blk_n[g] = !(vma && (a[CABD_BLK_HI:CABD_BLK_LO] == 3'(g)));
    end
  endgenerate

  assign sec_en = !blk_n[CABD_BLK_SEC];
  generate
    for (g = 0; g < 4; g++) begin : g_sub
      assign sub_n[g] = !(sec_en && (a[CABD_SUB_HI:CABD_SUB_LO] == 2'(g)));
    end
  endgenerate

  // second half code from region select and read/write
  assign reg_code   = {sub_n[CABD_SUB_REG], rd};
  assign sw_read    = (reg_code == CABD_CODE_READ);
  assign int_region = !blk_n[CABD_BLK_LOW] || sec_en || !blk_n[CABD_BLK_ROM];
  // 4000-DFFF left to the external bank
  assign ext_region = vma && !int_region;

  always_comb begin
    next_sel = '0;
    next_bus = '0;
    next_sel.cpu_ram_sel            = vma && cpu_ram;
    next_sel.peripheral_group_sel_n = !(page0 && a[CABD_PAGE_GRP_BIT]);
    next_sel.peripheral_sub_select  = a[CABD_PERIPH_BIT];
    // GPIB gated by clock and valid address
    next_sel.gpib_sel    = !next_sel.peripheral_group_sel_n && a[CABD_PERIPH_BIT]
                           && clk_b && vma;
    next_sel.adapter_sel = !next_sel.peripheral_group_sel_n && !a[CABD_PERIPH_BIT];
    next_sel.adapter_clk   = clk_b;
    next_sel.sys_ram_sel_n = sub_n[CABD_SUB_RAM];
    next_sel.sys_rom_sel_n = blk_n[CABD_BLK_ROM];
    next_sel.sig_trigger_n = sub_n[CABD_SUB_SIG];
    // latch strobe in clock low half
    next_sel.latch_write_strobe  = !((reg_code == CABD_CODE_WRITE) && !clk_b);
    next_sel.switch_read_strobe  = !sw_read;
    next_sel.switch_reg_enable_n = !sw_read;
    // internal enable, suppressed for on-chip RAM and switch read
    next_bus.internal_data_enable_n = !(int_region && !cpu_ram && !sw_read);
    next_bus.int_read_en  = clk_b && !next_bus.internal_data_enable_n && rd;
    next_bus.int_write_oe = !next_bus.internal_data_enable_n && !rd;
    next_bus.ext_bus_en   = ext_region;
    next_bus.ext_dir_read = rd;
    if (!next_bus.internal_data_enable_n) begin
      next_bus.ext_bus_en = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // one register stage keeps outputs glitch free, one cycle late
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_o <= '{default: 1'b1, cpu_ram_sel: 1'b0, peripheral_sub_select: 1'b0,
                 gpib_sel: 1'b0, adapter_sel: 1'b0, adapter_clk: 1'b0};
      bus_o <= '{internal_data_enable_n: 1'b1, default: 1'b0};
    end else begin
      sel_o <= next_sel;
      bus_o <= next_bus;
    end
  end

  // write data latch follows while clock high, holds otherwise
  logic [7:0] wr_latch;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_latch <= CABD_LATCH_RST;
    end else if (clk_b) begin
      wr_latch <= cpu_data_i;
    end
  end

  // latch keeps capturing while its outputs are off
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      int_data_o    <= CABD_LATCH_RST;
      int_data_oe_o <= 1'b0;
    end else begin
      int_data_o    <= clk_b ? cpu_data_i : wr_latch;
      int_data_oe_o <= next_bus.int_write_oe;
    end
  end

  // circuit select latch loads in clock low half
  // no read path from this latch
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_latch_o <= CABD_LATCH_RST;
    end else if (!next_sel.latch_write_strobe) begin
      sel_latch_o <= cpu_data_i;
    end
  end

  // switches onto processor data only when enabled
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cpu_data_o    <= 8'h00;
      cpu_data_oe_o <= 1'b0;
    end else begin
      cpu_data_o    <= sw_read ? switch_i : 8'h00;
      cpu_data_oe_o <= sw_read;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_excl;
    @(posedge mclk_i) disable iff (!rst_n)
      !(!bus_o.internal_data_enable_n && bus_o.ext_bus_en);
  endproperty
  a_excl: assert property (p_excl) else $error("both buses on");

  property p_gpib;
    @(posedge mclk_i) disable iff (!rst_n)
      sel_o.gpib_sel |-> ($past(clk_b) && $past(vma));
  endproperty
  a_gpib: assert property (p_gpib) else $error("gpib select ungated");

  property p_ram;
    @(posedge mclk_i) disable iff (!rst_n)
      (vma && a[15:11] == 5'h04) |=> !sel_o.sys_ram_sel_n;
  endproperty
  a_ram: assert property (p_ram) else $error("system RAM not selected");

  property p_rom;
    @(posedge mclk_i) disable iff (!rst_n)
      (vma && a[15:13] == 3'h7) |=> (!sel_o.sys_rom_sel_n && bus_o.internal_data_enable_n == 1'b0);
  endproperty
  a_rom: assert property (p_rom) else $error("ROM access wrong");

  property p_swrd;
    @(posedge mclk_i) disable iff (!rst_n)
      (vma && rd && a == CABD_SWITCH_REG_ADDR) |=>
        (!sel_o.switch_reg_enable_n && bus_o.internal_data_enable_n
         && !bus_o.ext_bus_en && cpu_data_oe_o);
  endproperty
  a_swrd: assert property (p_swrd) else $error("switch read wrong");

  sequence s_latch_wr;
    vma && !rd && !clk_b && a == CABD_SEL_LATCH_ADDR;
  endsequence
  property p_latch;
    @(posedge mclk_i) disable iff (!rst_n)
      s_latch_wr |=> (sel_latch_o == $past(cpu_data_i));
  endproperty
  a_latch: assert property (p_latch) else $error("latch not loaded");

  property p_ext;
    @(posedge mclk_i) disable iff (!rst_n)
      (vma && a[15:14] != 2'h0 && a[15:13] != 3'h7) |=>
        (bus_o.ext_bus_en && bus_o.ext_dir_read == $past(rd));
  endproperty
  a_ext: assert property (p_ext) else $error("external bus wrong");

  property p_cram;
    @(posedge mclk_i) disable iff (!rst_n)
      (vma && a[15:7] == 9'h000) |=> (sel_o.cpu_ram_sel && bus_o.internal_data_enable_n);
  endproperty
  a_cram: assert property (p_cram) else $error("on-chip RAM access wrong");

  property p_rdbuf;
    @(posedge mclk_i) disable iff (!rst_n)
      bus_o.int_read_en |-> ($past(clk_b) && $past(rd));
  endproperty
  a_rdbuf: assert property (p_rdbuf) else $error("read buffer ungated");

  property p_hold;
    @(posedge mclk_i) disable iff (!rst_n)
      (!clk_b && $past(!clk_b)) |=> int_data_o == $past(int_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("write latch not held");

  property p_pgrp;
    @(posedge mclk_i) disable iff (!rst_n)
      (a[15:7] == 9'h001) |=> !sel_o.peripheral_group_sel_n;
  endproperty
  a_pgrp: assert property (p_pgrp) else $error("peripheral group not selected");

  // Any high page bit must keep every page-zero select quiet
  property p_p0off;
    @(posedge mclk_i) disable iff (!rst_n)
      (a[15:8] != 8'h00) |=> (sel_o.peripheral_group_sel_n && !sel_o.cpu_ram_sel);
  endproperty
  a_p0off: assert property (p_p0off) else $error("page zero decoded off page");

  property p_half;
    @(posedge mclk_i) disable iff (!rst_n)
      (a[15:7] == 9'h001) |=> (sel_o.peripheral_sub_select == $past(a[CABD_PERIPH_BIT])
                               && sel_o.adapter_sel == !$past(a[CABD_PERIPH_BIT]));
  endproperty
  a_half: assert property (p_half) else $error("peripheral half wrong");

  property p_aclk;
    @(posedge mclk_i) disable iff (!rst_n)
      sel_o.adapter_clk == $past(clk_b);
  endproperty
  a_aclk: assert property (p_aclk) else $error("adapter clock not direct");

  // Without a valid address no primary or secondary select may fire
  property p_novma;
    @(posedge mclk_i) disable iff (!rst_n)
      !vma |=> (sel_o.sys_rom_sel_n && sel_o.sys_ram_sel_n && sel_o.sig_trigger_n
                && !bus_o.ext_bus_en);
  endproperty
  a_novma: assert property (p_novma) else $error("select without valid address");

  property p_sig;
    @(posedge mclk_i) disable iff (!rst_n)
      (vma && a[15:11] == 5'h07) |=> !sel_o.sig_trigger_n;
  endproperty
  a_sig: assert property (p_sig) else $error("signature trigger missing");

  property p_idata;
    @(posedge mclk_i) disable iff (!rst_n)
      (vma && a[15:14] == 2'h0 && a[15:7] != 9'h000 && !(rd && a[15:11] == 5'h06))
        |=> !bus_o.internal_data_enable_n;
  endproperty
  a_idata: assert property (p_idata) else $error("internal data enable missing");

  property p_wroe;
    @(posedge mclk_i) disable iff (!rst_n)
      int_data_oe_o |-> (!bus_o.internal_data_enable_n && !bus_o.ext_bus_en);
  endproperty
  a_wroe: assert property (p_wroe) else $error("write latch drives off region");

  property p_swoe;
    @(posedge mclk_i) disable iff (!rst_n)
      cpu_data_oe_o |-> !sel_o.switch_reg_enable_n;
  endproperty
  a_swoe: assert property (p_swoe) else $error("switches drive while disabled");

endmodule
`default_nettype wire

// *** core/cabd_pkg.sv ***
// Package: constants and carrier types for the cpu address and bus decoder
`default_nettype none
package cabd_pkg;
  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] CABD_SWITCH_REG_ADDR = 16'h3000; // switch register, read
  localparam logic [15:0] CABD_SEL_LATCH_ADDR  = 16'h3000; // select latch, write
  localparam int          CABD_PAGE_HI         = 15;
  localparam int          CABD_PAGE_LO         = 8;
  localparam int          CABD_PAGE_GRP_BIT    = 7;
  localparam int          CABD_PERIPH_BIT      = 6;
  localparam int          CABD_BLK_HI          = 15;
  localparam int          CABD_BLK_LO          = 13;
  localparam int          CABD_SUB_HI          = 12;
  localparam int          CABD_SUB_LO          = 11;
  localparam logic [2:0]  CABD_BLK_LOW         = 3'h0; // 0000-1FFF
  localparam logic [2:0]  CABD_BLK_SEC         = 3'h1; // 2000-3FFF
  localparam logic [2:0]  CABD_BLK_ROM         = 3'h7; // E000-FFFF
  localparam logic [1:0]  CABD_SUB_RAM         = 2'h0; // 2000-27FF
  localparam logic [1:0]  CABD_SUB_REG         = 2'h2; // 3000-37FF
  localparam logic [1:0]  CABD_SUB_SIG         = 2'h3; // 3800-3FFF
  localparam logic [1:0]  CABD_CODE_WRITE      = 2'h0; // region, write
  localparam logic [1:0]  CABD_CODE_READ       = 2'h1; // region, read
  localparam logic [7:0]  CABD_LATCH_RST       = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] internal_addr_bits;
    logic        internal_valid_addr;
    logic        buffered_valid_addr;
    logic        internal_read_write;
    logic        buffered_sys_clock;
  } cabd_cpu_t;

  typedef struct packed {
    logic cpu_ram_sel;             // on-chip RAM access
    logic peripheral_group_sel_n;  // 0080-00FF
    logic peripheral_sub_select;   // high: GPIB half
    logic gpib_sel;                // gated GPIB select
    logic adapter_sel;             // adapter half
    logic adapter_clk;             // adapter clock
    logic sys_ram_sel_n;
    logic sys_rom_sel_n;
    logic sig_trigger_n;
    logic latch_write_strobe;      // active low
    logic switch_read_strobe;      // active low
    logic switch_reg_enable_n;
  } cabd_sel_t;

  typedef struct packed {
    logic internal_data_enable_n;
    logic int_read_en;
    logic int_write_oe;
    logic ext_bus_en;
    logic ext_dir_read;
  } cabd_bus_t;
endpackage
`default_nettype wire

// *** bench/cabd_cpu_model.sv ***
// Processor-side model: drives address, valid address, read/write and clock phase
`default_nettype none
module cabd_cpu_model
(
  input  wire logic [15:0]         addr_i,  // Requested address
  input  wire logic                vma_i,   // Valid address
  input  wire logic                rd_i,    // 1 = read
  input  wire logic                phase_i, // Buffered clock level
  output cabd_pkg::cabd_cpu_t      cpu_o    // Bus toward decoder
);
  timeunit 1ns;
  timeprecision 1ps;
  import cabd_pkg::*;
  // ----------------------------------------------------------------
  // Bus drive
  // ----------------------------------------------------------------
  // With no valid address the lines carry junk, never a clean stale value
  always_comb begin
    cpu_o.internal_addr_bits  = vma_i ? addr_i : (16'ha5a5 ^ {16{phase_i}});
    cpu_o.internal_valid_addr = vma_i;
    cpu_o.buffered_valid_addr = vma_i;
    cpu_o.internal_read_write = rd_i;
    cpu_o.buffered_sys_clock  = phase_i;
  end
endmodule
`default_nettype wire

// *** bench/cabd_decoder_test.sv ***
// Self-checking bench for the address and bus decoder
`default_nettype none
module cabd_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cabd_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [15:0] addr   = 16'h0000;
  logic        vma    = 1'b0;
  logic        rd     = 1'b1;
  logic        phase  = 1'b0;
  logic [7:0]  wdata  = 8'h00;
  logic [7:0]  sw     = 8'hc3;
  cabd_cpu_t   cpu;
  cabd_sel_t   sel;
  cabd_bus_t   bus;
  logic [7:0]  idata, cdata, latch;
  logic        ioe, coe;
  int          n_fail = 0;
  int          compares = 0;
  always #5 mclk_i = ~mclk_i;
  cabd_cpu_model u_cpu (.addr_i(addr), .vma_i(vma), .rd_i(rd), .phase_i(phase), .cpu_o(cpu));
  cabd_decoder u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cpu_i(cpu), .cpu_data_i(wdata),
    .switch_i(sw), .int_data_o(idata), .int_data_oe_o(ioe), .cpu_data_o(cdata),
    .cpu_data_oe_o(coe), .sel_latch_o(latch), .sel_o(sel), .bus_o(bus));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Outputs answer one edge after the inputs are taken
  task automatic acc(input logic [15:0] a, input logic r, input logic ck, input logic [7:0] d);
    @(posedge mclk_i);
    addr  <= a;
    vma   <= 1'b1;
    rd    <= r;
    phase <= ck;
    wdata <= d;
    @(posedge mclk_i);
    #1;
    chk((bus.int_read_en | bus.int_write_oe) & bus.ext_bus_en, 16'h0000);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_page0;
    acc(16'h007f, 1'b1, 1'b1, 8'h00);
    chk({sel.cpu_ram_sel, bus.internal_data_enable_n}, 16'h0003);
    acc(16'h008f, 1'b1, 1'b0, 8'h00);
    chk({sel.peripheral_group_sel_n, sel.adapter_sel, sel.peripheral_sub_select}, 16'h0002);
    chk(sel.adapter_clk, 16'h0000);
    acc(16'h00c0, 1'b1, 1'b1, 8'h00);
    chk({sel.gpib_sel, sel.peripheral_sub_select, sel.adapter_clk}, 16'h0007);
    acc(16'h00c7, 1'b1, 1'b0, 8'h00);
    chk(sel.gpib_sel, 16'h0000);
    acc(16'h0180, 1'b1, 1'b1, 8'h00);
    chk({sel.peripheral_group_sel_n, sel.gpib_sel, sel.cpu_ram_sel}, 16'h0004);
    $display("test page0 done");
  endtask
  task automatic t_primary;
    acc(16'he000, 1'b1, 1'b1, 8'h00);
    chk({sel.sys_rom_sel_n, bus.internal_data_enable_n, bus.ext_bus_en}, 16'h0000);
    acc(16'h4000, 1'b1, 1'b1, 8'h00);
    chk({sel.sys_rom_sel_n, bus.internal_data_enable_n, bus.ext_bus_en, bus.ext_dir_read},
        16'h000f);
    acc(16'hdfff, 1'b0, 1'b1, 8'h00);
    chk({bus.ext_bus_en, bus.ext_dir_read, bus.internal_data_enable_n}, 16'h0005);
    acc(16'h1fff, 1'b1, 1'b1, 8'h00);
    chk({bus.internal_data_enable_n, bus.ext_bus_en}, 16'h0000);
    @(posedge mclk_i);
    addr <= 16'he000;
    vma  <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk(sel.sys_rom_sel_n, 16'h0001);
    $display("test primary done");
  endtask
  task automatic t_secondary;
    acc(16'h2000, 1'b1, 1'b1, 8'h00);
    chk({sel.sys_ram_sel_n, sel.sig_trigger_n}, 16'h0001);
    acc(16'h27ff, 1'b1, 1'b1, 8'h00);
    chk(sel.sys_ram_sel_n, 16'h0000);
    acc(16'h2800, 1'b1, 1'b1, 8'h00);
    chk({sel.sys_ram_sel_n, sel.sig_trigger_n, bus.internal_data_enable_n}, 16'h0006);
    acc(16'h3fff, 1'b0, 1'b1, 8'h00);
    chk({sel.sys_ram_sel_n, sel.sig_trigger_n}, 16'h0002);
    $display("test secondary done");
  endtask
  task automatic t_regs;
    acc(16'h3000, 1'b0, 1'b0, 8'h5a);
    chk({sel.latch_write_strobe, sel.switch_read_strobe, sel.switch_reg_enable_n}, 16'h0003);
    chk(latch, 16'h005a);
    // Latch is never read back; its copy lives in software
    acc(16'h3000, 1'b1, 1'b1, 8'h00);
    chk({sel.switch_read_strobe, sel.switch_reg_enable_n, sel.latch_write_strobe}, 16'h0001);
    chk({coe, cdata}, {8'h01, sw});
    chk({bus.internal_data_enable_n, bus.ext_bus_en, bus.int_read_en}, 16'h0004);
    chk(latch, 16'h005a);
    // The switch select covers 3000-37FF, so step outside that region
    acc(16'h3800, 1'b1, 1'b1, 8'h00);
    chk({sel.switch_reg_enable_n, coe}, 16'h0002);
    $display("test regs done");
  endtask
  task automatic t_datapath;
    acc(16'h2010, 1'b0, 1'b1, 8'h33);
    chk({ioe, bus.int_write_oe, idata}, {8'h03, 8'h33});
    acc(16'h2011, 1'b0, 1'b0, 8'h44);
    chk(idata, 16'h0033);
    acc(16'h4010, 1'b0, 1'b1, 8'h66);
    chk({ioe, bus.int_write_oe}, 16'h0000);
    acc(16'h2012, 1'b1, 1'b1, 8'h00);
    chk({bus.int_read_en, ioe}, 16'h0002);
    acc(16'h2013, 1'b1, 1'b0, 8'h00);
    chk(bus.int_read_en, 16'h0000);
    acc(16'h8000, 1'b1, 1'b1, 8'h00);
    chk(bus.int_read_en, 16'h0000);
    $display("test datapath done");
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    t_page0();
    t_primary();
    t_secondary();
    t_regs();
    t_datapath();
    results();
  end
  // Guard against a stalled run
  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
